/* design/cfpc_defs.svh */
// Purpose: Shared constants for the configuration pin control block
// Assumes: 10 MHz system clock
// Notes:   Times kept in their own unit, cycle counts derived from them
`ifndef CFPC_DEFS_SVH
`define CFPC_DEFS_SVH

// ==========================================================
// Clock and timing
`define CFPC_CLK_PERIOD_NS 100
`define CFPC_POR_TIME_NS   100000
`define CFPC_ERR_TIME_NS   2000
// Least times round up to whole cycles
`define CFPC_POR_CYCLES    ((`CFPC_POR_TIME_NS + `CFPC_CLK_PERIOD_NS - 1) / `CFPC_CLK_PERIOD_NS)
`define CFPC_ERR_CYCLES    ((`CFPC_ERR_TIME_NS + `CFPC_CLK_PERIOD_NS - 1) / `CFPC_CLK_PERIOD_NS)
`define CFPC_TMR_W         16

// ==========================================================
// Scheme select encodings
`define CFPC_SCHEME_W      3
`define CFPC_SCHEME_AS     3'h2
`define CFPC_SCHEME_AP     3'h3

// ==========================================================
// Pin synchroniser bundle: {scheme, req_n, status, complete, chain_n}
`define CFPC_PIN_W         7
`define CFPC_PIN_RESET     7'h0D

`endif

/* design/cfpc_pkg.sv */
// Purpose: Types for the configuration pin control block
// Assumes: Nothing beyond the defs header
// Notes:   States are one-hot
package cfpc_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [7:0] {
    ST_POR   = 8'h01,
    ST_WAIT  = 8'h02,
    ST_LOAD  = 8'h04,
    ST_INITW = 8'h08,
    ST_INIT  = 8'h10,
    ST_USER  = 8'h20,
    ST_CLEAR = 8'h40,
    ST_ERROR = 8'h80
  } cfpc_state_type;

endpackage

/* design/cfpc_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to CLK_SYS
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module cfpc_sync #(
  parameter int         W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk,   // System clock
  input  wire logic         rst,   // Sync reset
  input  wire logic [W-1:0] din,   // Raw pins
  output logic      [W-1:0] dout   // Filtered level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  wire  [W-1:0] agree = ~(s2_reg ^ s3_reg);

  // ==========================================================
  // Chain; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      dout   <= RESET_VAL;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout   <= (agree & s3_reg) | (~agree & dout);
    end
  end
endmodule

`default_nettype wire

/* design/cfpc_timer.sv */
// Purpose: Down-counting interval timer
// Assumes: count held stable while start pulses
// Notes:   Loads RESET_COUNT at reset so the power-on interval runs at once
`timescale 1ns/1ps
`default_nettype none
`include "cfpc_defs.svh"

module cfpc_timer #(
  parameter logic [`CFPC_TMR_W-1:0] RESET_COUNT = `CFPC_TMR_W'(`CFPC_POR_CYCLES)
) (
  input  wire logic clk,  // System clock
  input  wire logic rst,  // Sync reset
  cfpc_tmr_if.tmr   t     // Control carrier
);
  logic [`CFPC_TMR_W-1:0] cnt_reg;
  wire                    zero = (cnt_reg == '0);

  // Plain zero: no state that waits on expiry can raise start, and gating
  // with start would close a loop through the sequencer's next-state logic
  assign t.expired = zero;

  // ==========================================================
  // Count down to zero and stop
  always_ff @(posedge clk) begin
    if (rst)
      cnt_reg <= RESET_COUNT;
    else if (t.start)
      cnt_reg <= t.count;
    else if (!zero)
      cnt_reg <= cnt_reg - `CFPC_TMR_W'(1);
  end
endmodule

`default_nettype wire

/* design/cfpc_tmr_if.sv */
// Purpose: Carrier between the sequencer and its interval timer
// Assumes: One clock domain
// Notes:   start is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "cfpc_defs.svh"

interface cfpc_tmr_if;
  logic                   start;
  logic [`CFPC_TMR_W-1:0] count;
  logic                   expired;
  modport ctrl (output start, output count, input expired);
  modport tmr  (input start, input count, output expired);
endinterface

`default_nettype wire

/* design/cfpc_top.sv */
// Purpose: Pin-level sequencer for loading a configuration image
// Assumes: Data path reports image received, load errors, init finished
// Notes:   Open-drain pins are split into in, out, output enable
`timescale 1ns/1ps
`default_nettype none
`include "cfpc_defs.svh"

module cfpc_top (
  input  wire logic                     CLK_SYS,            // 10 MHz clock
  input  wire logic                     RST,                // Sync reset, high
  input  wire logic [`CFPC_SCHEME_W-1:0] SCHEME_SELECT,      // Strapped scheme pins
  input  wire logic                     CONFIG_REQUEST_N,   // Reload request pin
  input  wire logic                     STATUS_IN,          // Status pin level
  output logic                          STATUS_OUT,         // Status drive value
  output logic                          STATUS_OE,          // Status pull-down on
  input  wire logic                     CONFIG_COMPLETE_IN, // Completion pin level
  output logic                          CONFIG_COMPLETE_OUT,// Completion drive value
  output logic                          CONFIG_COMPLETE_OE, // Completion pull-down on
  input  wire logic                     CHAIN_ENABLE_N,     // Chain enable input
  output logic                          CHAIN_OUT,          // Chain output value
  output logic                          CHAIN_OE,           // Chain output enable
  input  wire logic                     DUAL_PURPOSE_OPT,   // Option on: chain pin dedicated
  input  wire logic                     USER_CHAIN_VALUE,   // User level for chain pin
  output logic                          SERIAL_MEMORY_SELECT_N, // Memory or flash select
  input  wire logic                     LOAD_DONE,          // Whole image received
  input  wire logic                     LOAD_ERROR,         // Load error seen
  input  wire logic                     INIT_DONE,          // Initialization finished
  output logic                          LOAD_ENABLE,        // Data path may load
  output logic                          INIT_START,         // Init begin pulse
  output logic                          CORE_RESET,         // Core held in reset
  output logic                          USER_IO_HIZ,        // User I/O tri-stated
  output logic                          USER_MODE,          // Configured and running
  output logic [`CFPC_SCHEME_W-1:0]     SCHEME,             // Latched scheme
  output logic                          ACTIVE_SERIAL_MODE, // Latched scheme is serial
  output logic                          ACTIVE_PARALLEL_MODE // Latched scheme is parallel
);
  import cfpc_pkg::*;

  // ==========================================================
  // Pin synchronisation
  logic [`CFPC_PIN_W-1:0] pins_s;
  cfpc_sync #(
    .W         (`CFPC_PIN_W),
    .RESET_VAL (`CFPC_PIN_RESET)
  ) u_sync (
    .clk  (CLK_SYS),
    .rst  (RST),
    .din  ({SCHEME_SELECT, CONFIG_REQUEST_N, STATUS_IN, CONFIG_COMPLETE_IN, CHAIN_ENABLE_N}),
    .dout (pins_s)
  );

  wire [`CFPC_SCHEME_W-1:0] scheme_s = pins_s[6:4];
  wire                      req_s    = pins_s[3];
  wire                      stat_s   = pins_s[2];
  wire                      done_s   = pins_s[1];
  wire                      chain_s  = pins_s[0];

  // ==========================================================
  // Interval timer for power-on and error hold
  cfpc_tmr_if tmr ();
  cfpc_timer #(
    .RESET_COUNT (`CFPC_TMR_W'(`CFPC_POR_CYCLES))
  ) u_timer (
    .clk (CLK_SYS),
    .rst (RST),
    .t   (tmr)
  );

  // ==========================================================
  // Sequencer state
  cfpc_state_type           state_reg;
  cfpc_state_type           state_next;
  logic [`CFPC_SCHEME_W-1:0] scheme_reg;

  function automatic logic is_active(input logic [`CFPC_SCHEME_W-1:0] s);
    is_active = (s == `CFPC_SCHEME_AS) || (s == `CFPC_SCHEME_AP);
  endfunction

  // Start condition: request high, status released, chain enabled
  wire start_ok   = req_s & stat_s & ~chain_s;
  wire load_fault = LOAD_ERROR | ~stat_s;
  wire enter_err  = (state_next == ST_ERROR) && (state_reg != ST_ERROR);

  assign tmr.start = enter_err;
  assign tmr.count = `CFPC_TMR_W'(`CFPC_ERR_CYCLES);

  // Next state; request low wins over everything once powered up
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_POR: begin
        if (tmr.expired) state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (start_ok) state_next = ST_LOAD;
      end
      ST_LOAD: begin
        if (!req_s) state_next = ST_CLEAR;
        else if (load_fault) state_next = ST_ERROR;
        else if (chain_s) state_next = ST_WAIT;
        else if (LOAD_DONE) state_next = ST_INITW;
      end
      ST_INITW: begin
        if (!req_s) state_next = ST_CLEAR;
        else if (!stat_s) state_next = ST_ERROR;
        else if (done_s) state_next = ST_INIT;
      end
      ST_INIT: begin
        if (!req_s) state_next = ST_CLEAR;
        else if (!stat_s) state_next = ST_ERROR;
        else if (INIT_DONE) state_next = ST_USER;
      end
      ST_USER: begin
        // Status and completion pins are not looked at here
        if (!req_s) state_next = ST_CLEAR;
      end
      ST_CLEAR: begin
        if (req_s) state_next = ST_WAIT;
      end
      ST_ERROR: begin
        if (!req_s) state_next = ST_CLEAR;
        else if (tmr.expired) state_next = ST_WAIT;
      end
      default: state_next = ST_POR;
    endcase
  end

  // ==========================================================
  // Output decode from the next state, so registered pins track state_reg
  wire n_cfg     = (state_next == ST_WAIT) || (state_next == ST_LOAD) || (state_next == ST_CLEAR) ||
                   (state_next == ST_POR) || (state_next == ST_ERROR);
  wire n_user    = (state_next == ST_USER);
  wire [`CFPC_SCHEME_W-1:0] scheme_n = ((state_reg == ST_WAIT) && (state_next == ST_LOAD)) ?
                                       scheme_s : scheme_reg;
  wire n_stat_oe = (state_next == ST_POR) || (state_next == ST_ERROR) ||
                   (state_next == ST_CLEAR);
  wire n_done_oe = n_cfg;
  wire n_chain_oe = n_user;
  wire n_chain   = DUAL_PURPOSE_OPT ? 1'b0 : USER_CHAIN_VALUE;
  // Select only asserted while an active scheme reads its image
  wire n_sel_n   = ~((state_next == ST_LOAD) && is_active(scheme_n));
  wire n_reset   = ~n_user;

  // State and scheme registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_reg  <= ST_POR;
      scheme_reg <= '0;
    end else begin
      state_reg  <= state_next;
      scheme_reg <= scheme_n;
    end
  end

  // Control outputs; open-drain pins only ever pull low
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      STATUS_OE              <= 1'b1;
      CONFIG_COMPLETE_OE     <= 1'b1;
      CHAIN_OE               <= 1'b0;
      CHAIN_OUT              <= 1'b0;
      SERIAL_MEMORY_SELECT_N <= 1'b1;
      CORE_RESET             <= 1'b1;
      USER_IO_HIZ            <= 1'b1;
      USER_MODE              <= 1'b0;
    end else begin
      STATUS_OE              <= n_stat_oe;
      CONFIG_COMPLETE_OE     <= n_done_oe;
      CHAIN_OE               <= n_chain_oe;
      CHAIN_OUT              <= n_chain;
      SERIAL_MEMORY_SELECT_N <= n_sel_n;
      CORE_RESET             <= n_reset;
      USER_IO_HIZ            <= n_reset;
      USER_MODE              <= n_user;
    end
  end

  // Data path handshakes and scheme flags
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      STATUS_OUT           <= 1'b0;
      CONFIG_COMPLETE_OUT  <= 1'b0;
      LOAD_ENABLE          <= 1'b0;
      INIT_START           <= 1'b0;
      SCHEME               <= '0;
      ACTIVE_SERIAL_MODE   <= 1'b0;
      ACTIVE_PARALLEL_MODE <= 1'b0;
    end else begin
      STATUS_OUT           <= 1'b0;
      CONFIG_COMPLETE_OUT  <= 1'b0;
      LOAD_ENABLE          <= (state_next == ST_LOAD);
      INIT_START           <= (state_next == ST_INIT) && (state_reg == ST_INITW);
      SCHEME               <= scheme_n;
      ACTIVE_SERIAL_MODE   <= (scheme_n == `CFPC_SCHEME_AS);
      ACTIVE_PARALLEL_MODE <= (scheme_n == `CFPC_SCHEME_AP);
    end
  end

  // ==========================================================
  // Assertions
  property p_por_status;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == ST_POR) |-> STATUS_OE && CONFIG_COMPLETE_OE;
  endproperty
  a_por_status: assert property (p_por_status) else $error("status not held low in power-on");

  // Completion pulled low while waiting for and reading the image
  property p_done_hold;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == ST_WAIT || state_reg == ST_LOAD) |-> CONFIG_COMPLETE_OE;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("completion released before image arrived");

  property p_user_drop;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == ST_USER && !req_s) |=> (state_reg == ST_CLEAR) && CORE_RESET && USER_IO_HIZ;
  endproperty
  a_user_drop: assert property (p_user_drop) else $error("request low did not clear user mode");

  property p_restart;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == ST_CLEAR && req_s) |=> (state_reg == ST_WAIT) && !STATUS_OE;
  endproperty
  a_restart: assert property (p_restart) else $error("request high did not restart");

  property p_load_err;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == ST_LOAD && req_s && LOAD_ERROR) |=> STATUS_OE ##1 STATUS_OE;
  endproperty
  a_load_err: assert property (p_load_err) else $error("load error not reported on status");

  property p_ext_status;
    @(posedge CLK_SYS) disable iff (RST)
    ((state_reg == ST_INIT || state_reg == ST_INITW) && req_s && !stat_s) |=> (state_reg == ST_ERROR);
  endproperty
  a_ext_status: assert property (p_ext_status) else $error("external status low ignored in init");

  property p_user_hold;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == ST_USER && req_s) |=> (state_reg == ST_USER) && USER_MODE;
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("user mode left without request");

  property p_done_release;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == ST_LOAD && req_s && !load_fault && !chain_s && LOAD_DONE) |=> !CONFIG_COMPLETE_OE;
  endproperty
  a_done_release: assert property (p_done_release) else $error("completion not released");

  property p_user_entry;
    @(posedge CLK_SYS) disable iff (RST)
    $rose(USER_MODE) |-> $past(state_reg, 2) == ST_INIT;
  endproperty
  a_user_entry: assert property (p_user_entry) else $error("user mode without init");

  property p_chain_gate;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == ST_WAIT && chain_s) |=> (state_reg != ST_LOAD) && !LOAD_ENABLE;
  endproperty
  a_chain_gate: assert property (p_chain_gate) else $error("load began with chain disabled");

  property p_chain_out;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == ST_USER && $past(DUAL_PURPOSE_OPT)) |-> CHAIN_OE && !CHAIN_OUT;
  endproperty
  a_chain_out: assert property (p_chain_out) else $error("chain output not low when configured");

  property p_select;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == ST_LOAD && is_active(scheme_reg)) |-> !SERIAL_MEMORY_SELECT_N && LOAD_ENABLE;
  endproperty
  a_select: assert property (p_select) else $error("memory select not asserted in active load");

  property p_err_exit;
    @(posedge CLK_SYS) disable iff (RST)
    $rose(state_reg == ST_ERROR) |-> ##[1:40] (state_reg != ST_ERROR);
  endproperty
  a_err_exit: assert property (p_err_exit) else $error("error state never left");

  c_user:  cover property (@(posedge CLK_SYS) disable iff (RST) $rose(USER_MODE));
  c_error: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(state_reg == ST_ERROR));
  c_clear: cover property (@(posedge CLK_SYS) disable iff (RST) state_reg == ST_USER ##1 state_reg == ST_CLEAR);

endmodule

`default_nettype wire

/* test/cfpc_host_model.sv */
// Purpose: Far side of the pin sequencer: pull-ups, image source, init logic
// Assumes: One clock; answer latency lat of 1 to 255 cycles
// Notes:   fail_load turns the next image answer into an error
`timescale 1ns/1ps
`default_nettype none

module cfpc_host_model (
  input  wire logic       clk,              // System clock
  input  wire logic       rst,              // Sync reset
  input  wire logic       load_enable,      // Device is loading
  input  wire logic       init_start,       // Init begin pulse
  input  wire logic       status_oe,        // Device pulls status
  input  wire logic       complete_oe,      // Device pulls completion
  input  wire logic       ext_status_low,   // Outside pull on status
  input  wire logic       ext_complete_low, // Outside pull on completion
  input  wire logic       fail_load,        // Answer with an error
  input  wire logic [7:0] lat,              // Answer latency
  output logic            status_pin,       // Resolved status wire
  output logic            complete_pin,     // Resolved completion wire
  output var logic        load_done,        // Image received
  output var logic        load_error,       // Image fault
  output var logic        init_done         // Init finished
);
  logic [7:0] load_cnt_reg;
  logic [7:0] init_cnt_reg;

  // ==========================================================
  // Wires
  // Open-drain lines with pull-ups, so a released line reads high
  assign status_pin   = ~(status_oe | ext_status_low);
  assign complete_pin = ~(complete_oe | ext_complete_low);

  // ==========================================================
  // Image source and init
  // Answers lat cycles into a load; a dropped enable clears it
  always_ff @(posedge clk) begin
    if (rst || !load_enable) begin
      load_cnt_reg <= 8'h00;
      load_done    <= 1'b0;
      load_error   <= 1'b0;
    end else if (load_cnt_reg == lat) begin
      load_done  <= ~fail_load;
      load_error <= fail_load;
    end else begin
      load_cnt_reg <= load_cnt_reg + 8'h01;
    end
  end

  // Init finishes lat cycles after its start pulse
  always_ff @(posedge clk) begin
    if (rst || load_enable) begin
      init_cnt_reg <= 8'h00;
      init_done    <= 1'b0;
    end else if (init_start) begin
      init_cnt_reg <= 8'h01;
    end else if (init_cnt_reg == lat) begin
      init_done <= 1'b1;
    end else if (init_cnt_reg != 8'h00) begin
      init_cnt_reg <= init_cnt_reg + 8'h01;
    end
  end
endmodule

`default_nettype wire

/* test/fpga_config_pin_control_bench.sv */
// Purpose: Self-checking bench for the configuration pin sequencer
// Assumes: Output bundle changes are predicted in order by the driver
// Notes:   Any bundle change with no note queued counts as a mismatch
`timescale 1ns/1ps
`default_nettype none
`include "cfpc_defs.svh"

module fpga_config_pin_control_bench;
  logic       clk_sys = 1'b0;
  logic       rst, req_n, chain_n, dual_opt, user_val, ext_st, ext_cc, fail_load, mon_on;
  logic [2:0] scheme_sel, scheme, s;
  logic [7:0] lat, obs, last_obs;
  logic       status_in, status_out, status_oe, cc_in, cc_out, cc_oe, chain_out, chain_oe;
  logic       sel_n, load_done, load_error, init_done, load_en, init_start;
  logic       core_rst, hiz, user_mode, act_s, act_p;
  logic [7:0] exp_q[$];
  int         fails, checks_done, starts;

  // Bundle of state-level outputs watched for changes
  assign obs = {user_mode, load_en, status_oe, cc_oe, sel_n, core_rst, hiz, chain_oe};

  always #50 clk_sys = ~clk_sys;

  cfpc_top uut (.CLK_SYS(clk_sys), .RST(rst), .SCHEME_SELECT(scheme_sel), .CONFIG_REQUEST_N(req_n),
    .STATUS_IN(status_in), .STATUS_OUT(status_out), .STATUS_OE(status_oe), .CONFIG_COMPLETE_IN(cc_in),
    .CONFIG_COMPLETE_OUT(cc_out), .CONFIG_COMPLETE_OE(cc_oe), .CHAIN_ENABLE_N(chain_n),
    .CHAIN_OUT(chain_out), .CHAIN_OE(chain_oe), .DUAL_PURPOSE_OPT(dual_opt), .USER_CHAIN_VALUE(user_val),
    .SERIAL_MEMORY_SELECT_N(sel_n), .LOAD_DONE(load_done), .LOAD_ERROR(load_error), .INIT_DONE(init_done),
    .LOAD_ENABLE(load_en), .INIT_START(init_start), .CORE_RESET(core_rst), .USER_IO_HIZ(hiz),
    .USER_MODE(user_mode), .SCHEME(scheme), .ACTIVE_SERIAL_MODE(act_s), .ACTIVE_PARALLEL_MODE(act_p));

  cfpc_host_model host (.clk(clk_sys), .rst(rst), .load_enable(load_en), .init_start(init_start),
    .status_oe(status_oe), .complete_oe(cc_oe), .ext_status_low(ext_st), .ext_complete_low(ext_cc),
    .fail_load(fail_load), .lat(lat), .status_pin(status_in), .complete_pin(cc_in),
    .load_done(load_done), .load_error(load_error), .init_done(init_done));

  // ==========================================================
  // Checking
  task automatic check(string what, logic [7:0] seen, logic [7:0] expv);
    checks_done++;
    if (seen !== expv) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Bounded wait for every queued note to be matched
  task automatic drain(int bound);
    for (int k = 0; k < bound && exp_q.size() != 0; k++) @(negedge clk_sys);
    if (exp_q.size() != 0) begin
      fails++;
      $display("unexpected pending_results expected 0 seen %0d", exp_q.size());
      report_and_stop();
    end
  endtask

  // Loading bundle: select low only in the two active schemes
  function automatic logic [7:0] load_obs(logic [2:0] sch);
    return (sch === `CFPC_SCHEME_AS || sch === `CFPC_SCHEME_AP) ? 8'h56 : 8'h5E;
  endfunction

  // Watcher: each change of the bundle takes the oldest note
  always @(negedge clk_sys) begin
    if (init_start === 1'b1) starts++; // Init pulses seen
    if (mon_on && !rst && obs !== last_obs) begin
      if (exp_q.size() == 0) check("outputs", obs, last_obs);
      else check("outputs", obs, exp_q.pop_front());
      last_obs = obs;
    end
  end

  // ==========================================================
  // Stimulus
  initial begin
    rst = 1'b1; req_n = 1'b0; chain_n = 1'b0; dual_opt = 1'b1; user_val = 1'b0;
    ext_st = 1'b0; ext_cc = 1'b0; fail_load = 1'b0; lat = 8'h05;
    scheme_sel = `CFPC_SCHEME_AS; s = `CFPC_SCHEME_AS;
    fails = 0; checks_done = 0; mon_on = 1'b0; last_obs = 8'h3E; starts = 0;
    void'($urandom(46));
    cyc(8);
    check("reset_outputs", obs, 8'h3E);
    rst = 1'b0;
    mon_on = 1'b1;
    exp_q.push_back(8'h1E);
    cyc(990);
    check("status_hold", 8'(status_oe), 8'h01);
    drain(100);
    // Full loads in serial, parallel and one passive scheme
    for (int i = 0; i < 3; i++) begin
      if (i == 0) s = `CFPC_SCHEME_AS;
      else if (i == 1) s = `CFPC_SCHEME_AP;
      else
        do s = 3'($urandom); while (s == `CFPC_SCHEME_AS || s == `CFPC_SCHEME_AP);
      scheme_sel = s;
      lat = 8'($urandom_range(30, 1));
      dual_opt = (i == 0) || ((i == 2) && 1'($urandom));
      cyc(6);
      if (i > 0) exp_q.push_back(8'h1E);
      exp_q.push_back(load_obs(s));
      exp_q.push_back(8'h0E);
      exp_q.push_back(8'h89);
      req_n = 1'b1;
      drain(300);
      check("init_pulses", 8'(starts), 8'(i + 1));
      check("scheme", 8'(scheme), 8'(s));
      check("serial_flag", 8'(act_s), 8'(s === `CFPC_SCHEME_AS));
      check("parallel_flag", 8'(act_p), 8'(s === `CFPC_SCHEME_AP));
      check("pin_drive", 8'({status_out, cc_out}), 8'h00);
      user_val = 1'($urandom);
      cyc(2);
      check("chain_pin", 8'(chain_out), dual_opt ? 8'h00 : 8'(user_val));
      // Outside pulls in user mode must leave every output alone
      ext_st = 1'b1;
      ext_cc = 1'b1;
      cyc(20);
      // Then random chatter on both lines, still with no effect
      repeat (10) begin
        ext_st = 1'($urandom);
        ext_cc = 1'($urandom);
        cyc(1);
      end
      ext_st = 1'b0;
      ext_cc = 1'b0;
      cyc(10);
      exp_q.push_back(8'h3E);
      req_n = 1'b0;
      drain(50);
    end
    // Load error, then hold and restart
    fail_load = 1'b1;
    lat = 8'h0A;
    exp_q.push_back(8'h1E);
    exp_q.push_back(8'h5E);
    exp_q.push_back(8'h3E);
    req_n = 1'b1;
    drain(100);
    fail_load = 1'b0;
    lat = 8'hC8;
    cyc(15);
    check("error_status", 8'(status_oe), 8'h01);
    exp_q.push_back(8'h1E);
    exp_q.push_back(8'h5E);
    drain(60);
    // Outside low on status mid-load; held low it blocks the restart
    exp_q.push_back(8'h3E);
    exp_q.push_back(8'h1E);
    ext_st = 1'b1;
    drain(60);
    cyc(40);
    exp_q.push_back(8'h5E);
    ext_st = 1'b0;
    drain(30);
    // Chain input high mid-load aborts and blocks until low again
    exp_q.push_back(8'h1E);
    chain_n = 1'b1;
    drain(30);
    cyc(30);
    exp_q.push_back(8'h5E);
    exp_q.push_back(8'h0E);
    exp_q.push_back(8'h89);
    chain_n = 1'b0;
    drain(600);
    check("init_pulses", 8'(starts), 8'h04);
    // Reset in mid-run: power-up values, power-on hold, then a full reload
    exp_q.push_back(8'h3E);
    exp_q.push_back(8'h1E);
    exp_q.push_back(8'h5E);
    exp_q.push_back(8'h0E);
    exp_q.push_back(8'h89);
    rst = 1'b1;
    cyc(4);
    check("reset_outputs", obs, 8'h3E);
    rst = 1'b0;
    drain(1700);
    check("init_pulses", 8'(starts), 8'h05);
    report_and_stop();
  end
endmodule

`default_nettype wire
